// [logic/obcr_defs.svh]
`ifndef OBCR_DEFS_SVH
`define OBCR_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define OBCR_ADDR_IDLE_RATE   8'h40
`define OBCR_ADDR_SWING       8'h42
`define OBCR_ADDR_DEEMPH      8'h43
`define OBCR_ADDR_GSWING      8'h47

// ****************************************
// reset values
// ****************************************
`define OBCR_RST_IDLE_RATE    8'h00
`define OBCR_RST_SWING        8'h03
`define OBCR_RST_DEEMPH       8'h03
`define OBCR_RST_GSWING       8'h02

// ****************************************
// writable bit masks, reserved bits clear
// ****************************************
`define OBCR_MASK_IDLE_RATE   8'h33
`define OBCR_MASK_SWING       8'h7f
`define OBCR_MASK_DEEMPH      8'hff
`define OBCR_MASK_GSWING      8'h03

// ****************************************
// field positions
// ****************************************
`define OBCR_BIT_IDLE_AUTO    5
`define OBCR_BIT_IDLE_SEL     4
`define OBCR_BIT_RATE_AUTO    1
`define OBCR_BIT_RATE_SEL     0
`define OBCR_BIT_DE_TYPE      7

// ****************************************
// swing codes
// ****************************************
`define OBCR_SW_600           7'h03
`define OBCR_SW_800           7'h07
`define OBCR_SW_1000          7'h0f
`define OBCR_SW_1200          7'h1f

// ****************************************
// de-emphasis full-byte codes
// ****************************************
`define OBCR_DE_0DB           8'h01
`define OBCR_DE_3P5DB         8'he8
`define OBCR_DE_6DB           8'h88
`define OBCR_DE_9DB           8'h90
`define OBCR_DE_12DB          8'ha0

// ****************************************
// global swing adjust codes
// ****************************************
`define OBCR_GS_M25           2'h0
`define OBCR_GS_M12P5         2'h1
`define OBCR_GS_0             2'h2
`define OBCR_GS_P12P5         2'h3

`endif

// [logic/obcr_pkg.sv]
`default_nettype none
package obcr_pkg;

   typedef enum logic [1:0] {
      OBCR_RATE_LOW,
      OBCR_RATE_HIGH,
      OBCR_RATE_AUTO
   } obcr_rate_t;

   typedef enum logic [2:0] {
      OBCR_SWING_600,
      OBCR_SWING_800,
      OBCR_SWING_1000,
      OBCR_SWING_1200,
      OBCR_SWING_BAD
   } obcr_swing_t;

   typedef enum logic [2:0] {
      OBCR_DE_0DB,
      OBCR_DE_3P5DB,
      OBCR_DE_6DB,
      OBCR_DE_9DB,
      OBCR_DE_12DB,
      OBCR_DE_OTHER
   } obcr_deemph_t;

   typedef enum logic [1:0] {
      OBCR_GS_MINUS25,
      OBCR_GS_MINUS12P5,
      OBCR_GS_NONE,
      OBCR_GS_PLUS12P5
   } obcr_gswing_t;

   // decoded lane1 output b conditioning, as seen by the analog driver
   typedef struct packed {
      logic         idle_auto;
      logic         mute;
      logic         signal_detector_en;
      obcr_rate_t   rate;
      obcr_swing_t  output_swing;
      logic         de_enhanced;
      logic [6:0]   de_level;
      obcr_deemph_t deemphasis_setting;
      obcr_gswing_t gswing;
   } obcr_cond_t;

endpackage

`default_nettype wire

// [logic/obcr_regs.sv]
// Summary of operation
// - bit5 picks automatic idle, else bit4
// - manual bit4 zero drives, one mutes
// - bit1 picks automatic rate, else bit0
// - manual bit0 picks low or high range
// - swing code decodes 600 to 1200 mV
// - de-emphasis bit7 type, low seven level
// - de-emphasis full-byte codes decode to dB
// - global adjust scales swing of all outputs
// - reset values 00, 03, 03, 02
`timescale 1ns/1ps
`default_nettype none
`include "obcr_defs.svh"

// ****************************************
// one register byte with write mask
// ****************************************
module obcr_reg_slice
   import obcr_pkg::*;
#(
   parameter logic [7:0] ADDR = '0,    // register offset
   parameter logic [7:0] MASK = '0,    // writable bits
   parameter logic [7:0] RST  = '0     // reset value
) (
   input  wire logic       mclk,       // 125 MHz clock
   input  wire logic       nrst,       // async reset, active low
   input  wire logic       wr_en,      // register write strobe
   input  wire logic [7:0] addr,       // register offset
   input  wire logic [7:0] wdata,      // write data
   output var  logic [7:0] value       // stored byte
);

   logic [7:0] next_value;

   // reserved bits never stored, so they always read zero
   always_comb begin
      next_value = value;
      if (wr_en && (addr == ADDR)) begin
         next_value = wdata & MASK;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         value <= RST;
      end else begin
         value <= next_value;
      end
   end

endmodule // obcr_reg_slice

module obcr_regs
   import obcr_pkg::*;
(
   input  wire logic       mclk,       // 125 MHz clock
   input  wire logic       nrst,       // async reset, active low
   input  wire logic       wr_en,      // register write strobe
   input  wire logic       rd_en,      // register read strobe
   input  wire logic [7:0] addr,       // register offset
   input  wire logic [7:0] wdata,      // write data
   output var  logic [7:0] rdata,      // read data, registered
   output var  logic       rd_valid,   // read data valid pulse
   output var  obcr_cond_t cond        // decoded conditioning
);

   // ****************************************
   // register storage
   // ****************************************
   logic [7:0] idle_rate;
   logic [7:0] swing;
   logic [7:0] deemph;
   logic [7:0] gswing;
   logic [7:0] next_rdata;
   logic       next_rd_valid;
   obcr_cond_t next_cond;

   obcr_reg_slice #(
      .ADDR (`OBCR_ADDR_IDLE_RATE),
      .MASK (`OBCR_MASK_IDLE_RATE),
      .RST  (`OBCR_RST_IDLE_RATE)
   ) u_idle_rate (
      .mclk  (mclk),
      .nrst  (nrst),
      .wr_en (wr_en),
      .addr  (addr),
      .wdata (wdata),
      .value (idle_rate)
   );

   obcr_reg_slice #(
      .ADDR (`OBCR_ADDR_SWING),
      .MASK (`OBCR_MASK_SWING),
      .RST  (`OBCR_RST_SWING)
   ) u_swing (
      .mclk  (mclk),
      .nrst  (nrst),
      .wr_en (wr_en),
      .addr  (addr),
      .wdata (wdata),
      .value (swing)
   );

   obcr_reg_slice #(
      .ADDR (`OBCR_ADDR_DEEMPH),
      .MASK (`OBCR_MASK_DEEMPH),
      .RST  (`OBCR_RST_DEEMPH)
   ) u_deemph (
      .mclk  (mclk),
      .nrst  (nrst),
      .wr_en (wr_en),
      .addr  (addr),
      .wdata (wdata),
      .value (deemph)
   );

   // gain field also scales the other outputs, only two bits stored
   obcr_reg_slice #(
      .ADDR (`OBCR_ADDR_GSWING),
      .MASK (`OBCR_MASK_GSWING),
      .RST  (`OBCR_RST_GSWING)
   ) u_gswing (
      .mclk  (mclk),
      .nrst  (nrst),
      .wr_en (wr_en),
      .addr  (addr),
      .wdata (wdata),
      .value (gswing)
   );

   // ****************************************
   // read port
   // ****************************************
   always_comb begin
      next_rd_valid = rd_en;
      next_rdata    = 8'h00;
      if (rd_en) begin
         case (addr)
            `OBCR_ADDR_IDLE_RATE: next_rdata = idle_rate;
            `OBCR_ADDR_SWING:     next_rdata = swing;
            `OBCR_ADDR_DEEMPH:    next_rdata = deemph;
            `OBCR_ADDR_GSWING:    next_rdata = gswing;
            default:              next_rdata = 8'h00;
         endcase
      end
   end

   // ****************************************
   // decode
   // ****************************************
   always_comb begin
      next_cond = '0;
      next_cond.idle_auto = idle_rate[`OBCR_BIT_IDLE_AUTO];
      // forced mode: detector off, output driven or muted per select bit
      next_cond.mute = !idle_rate[`OBCR_BIT_IDLE_AUTO]
                       && idle_rate[`OBCR_BIT_IDLE_SEL];
      next_cond.signal_detector_en = idle_rate[`OBCR_BIT_IDLE_AUTO];
      if (idle_rate[`OBCR_BIT_RATE_AUTO]) begin
         next_cond.rate = OBCR_RATE_AUTO;
      end else if (idle_rate[`OBCR_BIT_RATE_SEL]) begin
         next_cond.rate = OBCR_RATE_HIGH;
      end else begin
         next_cond.rate = OBCR_RATE_LOW;
      end
      case (swing[6:0])
         `OBCR_SW_600:  next_cond.output_swing = OBCR_SWING_600;
         `OBCR_SW_800:  next_cond.output_swing = OBCR_SWING_800;
         `OBCR_SW_1000: next_cond.output_swing = OBCR_SWING_1000;
         `OBCR_SW_1200: next_cond.output_swing = OBCR_SWING_1200;
         default:       next_cond.output_swing = OBCR_SWING_BAD;
      endcase
      next_cond.de_enhanced = deemph[`OBCR_BIT_DE_TYPE];
      next_cond.de_level    = deemph[6:0];
      case (deemph)
         `OBCR_DE_0DB:   next_cond.deemphasis_setting = OBCR_DE_0DB;
         `OBCR_DE_3P5DB: next_cond.deemphasis_setting = OBCR_DE_3P5DB;
         `OBCR_DE_6DB:   next_cond.deemphasis_setting = OBCR_DE_6DB;
         `OBCR_DE_9DB:   next_cond.deemphasis_setting = OBCR_DE_9DB;
         `OBCR_DE_12DB:  next_cond.deemphasis_setting = OBCR_DE_12DB;
         default:        next_cond.deemphasis_setting = OBCR_DE_OTHER;
      endcase
      case (gswing[1:0])
         `OBCR_GS_M25:   next_cond.gswing = OBCR_GS_MINUS25;
         `OBCR_GS_M12P5: next_cond.gswing = OBCR_GS_MINUS12P5;
         `OBCR_GS_0:     next_cond.gswing = OBCR_GS_NONE;
         `OBCR_GS_P12P5: next_cond.gswing = OBCR_GS_PLUS12P5;
         default:        next_cond.gswing = OBCR_GS_NONE;
      endcase
   end

   // ****************************************
   // read port registers
   // ****************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata    <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rdata    <= next_rdata;
         rd_valid <= next_rd_valid;
      end
   end

   // ****************************************
   // decode registers
   // ****************************************
   // one cycle of lag traded for glitch-free settings at the analog driver
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         // decode of reset values: driven, low range, 600 mV, gain unchanged
         cond <= '{idle_auto: 1'b0, mute: 1'b0, signal_detector_en: 1'b0,
                   rate: OBCR_RATE_LOW, output_swing: OBCR_SWING_600,
                   de_enhanced: 1'b0, de_level: 7'(`OBCR_RST_DEEMPH),
                   deemphasis_setting: OBCR_DE_OTHER,
                   gswing: OBCR_GS_NONE};
      end else begin
         cond <= next_cond;
      end
   end

endmodule // obcr_regs

`default_nettype wire

// [tb/obcr_regs_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module obcr_chk
   import obcr_pkg::*;
(
   input wire logic       mclk,     // clock
   input wire logic       nrst,     // reset
   input wire logic       wr_en,    // write
   input wire logic       rd_en,    // read
   input wire logic [7:0] addr,     // offset
   input wire logic [7:0] wdata,    // wdata
   input wire logic [7:0] rdata,    // rdata
   input wire logic       rd_valid, // valid
   input wire obcr_cond_t cond      // decode
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // ****
   // properties
   // ****
   // write not overwritten on the next edge, so cond shows it
   sequence s_wr(a);
      wr_en && addr == a ##1 !(wr_en && addr == a);
   endsequence
   // write of one given byte, same guard as s_wr
   sequence s_wr_d(a, d);
      wr_en && addr == a && wdata == d ##1 !(wr_en && addr == a);
   endsequence
   a_idle_rsv_zero: assert property (
      rd_en && addr == 8'h40 |=> rd_valid && rdata[7:6] == 2'h0 && rdata[3:2] == 2'h0)
      else $error("idle rsv");
   a_gsw_rsv_zero: assert property (
      rd_en && addr == 8'h47 |=> rd_valid && rdata[7:2] == 6'h00) else $error("gsw rsv");
   a_swing_rsv_zero: assert property (
      rd_en && addr == 8'h42 |=> rd_valid && !rdata[7]) else $error("swing rsv");
   a_mute_manual: assert property (
      s_wr(8'h40) |=> cond.mute == (!$past(wdata[5], 2) && $past(wdata[4], 2))) else $error("mute");
   a_rate_manual: assert property (
      s_wr(8'h40) |=> cond.rate == ($past(wdata[1], 2) ? OBCR_RATE_AUTO :
      ($past(wdata[0], 2) ? OBCR_RATE_HIGH : OBCR_RATE_LOW))) else $error("rate");
   a_sd_tracks: assert property (
      s_wr(8'h40) |=> cond.signal_detector_en == $past(wdata[5], 2)) else $error("detector");
   a_de_fields: assert property (
      s_wr(8'h43) |=> {cond.de_enhanced, cond.de_level} == $past(wdata, 2)) else $error("de");
   a_gsw_map: assert property (
      s_wr(8'h47) |=> cond.gswing == $past(wdata[1:0], 2)) else $error("gsw");
   a_swing_1000: assert property (
      s_wr_d(8'h42, 8'h0f) |=> cond.output_swing == OBCR_SWING_1000) else $error("swing");
   a_de_6db: assert property (
      s_wr_d(8'h43, 8'h88) |=> cond.deemphasis_setting == OBCR_DE_6DB) else $error("de code");
   a_reset_decode: assert property (
      $rose(nrst) |-> cond.output_swing == OBCR_SWING_600 && cond.gswing == OBCR_GS_NONE
      && cond.rate == OBCR_RATE_LOW && !cond.mute) else $error("reset decode");
endmodule // obcr_chk
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench
   import obcr_pkg::*;
;
   logic       mclk = 1'b0;
   logic       nrst = 1'b0;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic       rd_valid;
   obcr_cond_t cond;
   int         bad_count = 0;
   int         checked = 0;
   obcr_regs u_dut (.mclk(mclk), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid), .cond(cond));
   initial forever #4 mclk = ~mclk;
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // returns once cond reflects the write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(posedge mclk);
      #1;
      wr_en = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      #1;
      addr = a;
      rd_en = 1'b1;
      @(posedge mclk);
      #1;
      rd_en = 1'b0;
      cmp({7'h00, rd_valid}, 8'h01);
      cmp(rdata, exp);
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_reset;
      rd(8'h40, 8'h00);
      rd(8'h42, 8'h03);
      rd(8'h43, 8'h03);
      rd(8'h47, 8'h02);
      cmp({6'h00, cond.rate}, {6'h00, OBCR_RATE_LOW});
      cmp({5'h00, cond.output_swing}, {5'h00, OBCR_SWING_600});
      cmp({5'h00, cond.deemphasis_setting}, {5'h00, OBCR_DE_OTHER});
      cmp({6'h00, cond.gswing}, {6'h00, OBCR_GS_NONE});
      cmp({5'h00, cond.mute, cond.idle_auto, cond.signal_detector_en}, 8'h00);
   endtask
   task automatic t_idle_rate;
      logic [7:0] v[7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h01, 8'h02, 8'h03};
      for (int i = 0; i < 7; i++) begin
         wr(8'h40, v[i]);
         cmp({7'h00, cond.mute}, {7'h00, !v[i][5] && v[i][4]});
         cmp({7'h00, cond.idle_auto}, {7'h00, v[i][5]});
         cmp({7'h00, cond.signal_detector_en}, {7'h00, v[i][5]});
         cmp({6'h00, cond.rate}, {6'h00, v[i][1] ? OBCR_RATE_AUTO : obcr_rate_t'(v[i][0])});
      end
   endtask
   task automatic t_swing;
      logic [7:0] v[5] = '{8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f};
      obcr_swing_t e[5] = '{OBCR_SWING_600, OBCR_SWING_800, OBCR_SWING_1000,
         OBCR_SWING_1200, OBCR_SWING_BAD};
      for (int i = 0; i < 5; i++) begin
         wr(8'h42, v[i]);
         cmp({5'h00, cond.output_swing}, {5'h00, e[i]});
      end
   endtask
   task automatic t_deemph;
      logic [7:0] v[6] = '{8'h01, 8'he8, 8'h88, 8'h90, 8'ha0, 8'h03};
      obcr_deemph_t e[6] = '{OBCR_DE_0DB, OBCR_DE_3P5DB, OBCR_DE_6DB, OBCR_DE_9DB,
         OBCR_DE_12DB, OBCR_DE_OTHER};
      for (int i = 0; i < 6; i++) begin
         wr(8'h43, v[i]);
         cmp({5'h00, cond.deemphasis_setting}, {5'h00, e[i]});
         cmp({cond.de_enhanced, cond.de_level}, v[i]);
      end
   endtask
   task automatic t_gswing;
      for (int i = 0; i < 4; i++) begin
         wr(8'h47, i[7:0]);
         cmp({6'h00, cond.gswing}, i[7:0]);
      end
   endtask
   // unmapped 0x41 sits between two live offsets
   task automatic t_reserved;
      wr(8'h40, 8'hff);
      wr(8'h41, 8'hff);
      rd(8'h40, 8'h33);
      rd(8'h41, 8'h00);
      wr(8'h42, 8'hff);
      rd(8'h42, 8'h7f);
      wr(8'h47, 8'hff);
      rd(8'h47, 8'h03);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      #1;
      nrst = 1'b1;
      t_reset();
      t_idle_rate();
      t_swing();
      t_deemph();
      t_gswing();
      t_reserved();
      nrst = 1'b0;
      @(posedge mclk);
      #1;
      nrst = 1'b1;
      t_reset();
      print_verdict();
   end
endmodule // testbench
bind obcr_regs obcr_chk u_chk (.mclk(mclk), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en),
   .addr(addr), .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid), .cond(cond));
`default_nettype wire
